/* File: rtl/rff_defs.vh */
// Purpose: constants for the receive frame filter and event block
// Assumes: 16-bit registers on a plain strobe port
// Notes:   offsets are byte addresses of 16-bit words on the register port
`ifndef RFF_DEFS_VH
`define RFF_DEFS_VH
`define RFF_ADDR_W        12
`define RFF_OFS_CTL       12'h104
`define RFF_OFS_CFG       12'h102
`define RFF_OFS_EVENT     12'h124
`define RFF_OFS_STATUS    12'h400
`define RFF_OFS_LEN       12'h402
`define RFF_OFS_ADDR01    12'h158
`define RFF_OFS_ADDR23    12'h15a
`define RFF_OFS_ADDR45    12'h15c
// Configuration field, destination length, reset values and identification codes
`define RFF_C_DMA         9
`define RFF_DEST_BYTES    11'd6
`define RFF_CTL_RESET     16'h0005
`define RFF_CTL_ID        6'h05
`define RFF_EVT_ID        6'h04
`define RFF_CFG_RESET     16'h0003
`define RFF_CFG_ID        6'h03
`define RFF_ID_MASK       16'h003f
// Control fields
`define RFF_B_IAHASH      6
`define RFF_B_PROMISC     7
`define RFF_B_GOOD        8
`define RFF_B_MCAST       9
`define RFF_B_OWN         10
`define RFF_B_BCAST       11
`define RFF_B_CRC         12
`define RFF_B_SHORT       13
`define RFF_B_OVER        14
// Event fields
`define RFF_E_IAHASH      6
`define RFF_E_DRIBBLE     7
`define RFF_E_GOOD        8
`define RFF_E_HASHED      9
`define RFF_E_OWN         10
`define RFF_E_BCAST       11
`define RFF_E_CRC         12
`define RFF_E_SHORT       13
`define RFF_E_OVER        14
// Length counter width and length limits in bytes
`define RFF_LEN_W         11
`define RFF_MIN_LEN       11'd64
`define RFF_MAX_LEN       11'd1518
`define RFF_FLOOR_LEN     11'd8
`endif

/* File: rtl/rff_filter.v */
// Purpose: destination filtering, frame sorting and receive event report
// Assumes: MAC front end supplies bytes, hash results and frame end flags
// Notes:   register port answers in the cycle after a read strobe
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
`include "rff_defs.vh"
module rff_filter #(
    parameter LEN_W = `RFF_LEN_W
) (
    // Clock and reset
    input  wire                   clk_sys,
    input  wire                   rst,
    // Register port
    input  wire [`RFF_ADDR_W-1:0] reg_addr,
    input  wire [15:0]            reg_wdata,
    input  wire                   reg_wr,
    input  wire                   reg_rd,
    output reg  [15:0]            reg_rdata,
    // Received byte stream from the medium side
    input  wire                   rx_start,
    input  wire                   rx_byte_valid,
    input  wire [7:0]             rx_byte,
    input  wire                   rx_end,
    input  wire                   rx_fcs_ok,
    input  wire [2:0]             rx_extra_bits,
    input  wire                   rx_hash_hit,
    input  wire [5:0]             rx_hash_index,
    // Store side
    output reg                    store_valid,
    output reg  [7:0]             store_byte,
    output reg                    frame_commit,
    output reg                    frame_discard,
    output reg                    dma_only_receive,
    output reg                    irq
);
    reg [15:0]      receive_filter_control;
    reg [15:0]      receive_configuration;
    reg [15:0]      receive_frame_event;
    reg [15:0]      receive_status_copy;
    reg [LEN_W-1:0] frame_len;
    reg [15:0]      length_copy;
    reg [47:0]      station_addr;
    reg [47:0]      dest_addr;
    reg [LEN_W-1:0] byte_cnt;
    reg             in_frame;
    reg [15:0]      next_event;
    reg             next_keep;
    reg [15:0]      next_rdata;

    wire ctl_wr = reg_wr && (reg_addr == `RFF_OFS_CTL);
    wire evt_rd = reg_rd && (reg_addr == `RFF_OFS_EVENT);

    // Frame classification; the length classes use the final byte count
    wire is_bcast  = (dest_addr == {48{1'b1}});
    wire is_mcast  = dest_addr[40] && !is_bcast;
    wire is_own    = (dest_addr == station_addr);
    wire is_short  = (frame_len < `RFF_MIN_LEN);
    wire is_over   = (frame_len > `RFF_MAX_LEN);
    wire is_tiny   = (frame_len < `RFF_FLOOR_LEN);
    wire is_good   = rx_fcs_ok && !is_short && !is_over;
    wire [15:0] c  = receive_filter_control;

    wire own_hit   = c[`RFF_B_OWN] && is_own;
    wire bc_hit    = c[`RFF_B_BCAST] && is_bcast;
    wire mc_hit    = c[`RFF_B_MCAST] && is_mcast && rx_hash_hit;
    wire ia_hit    = c[`RFF_B_IAHASH] && !dest_addr[40]
                     && rx_hash_hit;
    wire addr_pass = c[`RFF_B_PROMISC] || own_hit || bc_hit
                     || mc_hit || ia_hit;

    // Keep decision at frame end: address filter first, then frame type
    always @* begin
        next_keep = addr_pass;
        if (is_tiny) begin
            next_keep = 1'b0;
        end
        if (is_good && !c[`RFF_B_GOOD]) begin
            next_keep = 1'b0;
        end
        if (!rx_fcs_ok && !c[`RFF_B_CRC]) begin
            next_keep = 1'b0;
        end
        if (is_short && !c[`RFF_B_SHORT]) begin
            next_keep = 1'b0;
        end
        if (is_over && !c[`RFF_B_OVER]) begin
            next_keep = 1'b0;
        end
    end

    // Event image for the frame that just ended
    always @* begin
        next_event = 16'h0000;
        next_event[`RFF_E_GOOD]    = is_good;
        next_event[`RFF_E_CRC]     = !rx_fcs_ok;
        next_event[`RFF_E_SHORT]   = is_short;
        next_event[`RFF_E_OVER]    = is_over;
        next_event[`RFF_E_DRIBBLE] = (rx_extra_bits != 3'h0);
        next_event[`RFF_E_OWN]     = is_own;
        next_event[`RFF_E_BCAST]   = is_bcast && is_good
                                     && c[`RFF_B_BCAST];
        next_event[`RFF_E_HASHED]  = rx_hash_hit && !is_bcast;
        next_event[`RFF_E_IAHASH]  = ia_hit;
        // Hashed good frames trade the upper flags for the table index
        if (next_event[`RFF_E_HASHED] && is_good) begin
            next_event[15:10] = rx_hash_index;
        end
    end

    // Read mux; control and configuration identification bits are forced, not stored
    always @* begin
        case (reg_addr)
            `RFF_OFS_CTL: begin
                next_rdata = (c & ~`RFF_ID_MASK)
                             | {10'h000, `RFF_CTL_ID};
            end
            `RFF_OFS_CFG: begin
                next_rdata = (receive_configuration & ~`RFF_ID_MASK)
                             | {10'h000, `RFF_CFG_ID};
            end
            `RFF_OFS_EVENT: begin
                next_rdata = receive_frame_event;
            end
            `RFF_OFS_STATUS: begin
                next_rdata = receive_status_copy;
            end
            `RFF_OFS_LEN: begin
                next_rdata = length_copy;
            end
            `RFF_OFS_ADDR01: begin
                next_rdata = station_addr[15:0];
            end
            `RFF_OFS_ADDR23: begin
                next_rdata = station_addr[31:16];
            end
            `RFF_OFS_ADDR45: begin
                next_rdata = station_addr[47:32];
            end
            default: begin
                next_rdata = 16'h0000;
            end
        endcase
    end

    // Register port decodes
    wire cfg_wr    = reg_wr && (reg_addr == `RFF_OFS_CFG);
    wire addr01_wr = reg_wr && (reg_addr == `RFF_OFS_ADDR01);
    wire addr23_wr = reg_wr && (reg_addr == `RFF_OFS_ADDR23);
    wire addr45_wr = reg_wr && (reg_addr == `RFF_OFS_ADDR45);

    // Frame progress
    wire frame_done = in_frame && rx_end;
    wire decide     = !in_frame && (frame_len != {LEN_W{1'b0}});

    // Interrupt causes, each gated by its enable in the configuration
    wire [15:0] cf  = receive_configuration;
    wire irq_over   = is_over && cf[`RFF_B_OVER];
    wire irq_fcs    = !rx_fcs_ok && cf[`RFF_B_CRC];
    wire irq_short  = is_short && cf[`RFF_B_SHORT];
    wire irq_good   = is_good && cf[`RFF_B_GOOD];
    wire irq_any    = irq_over || irq_fcs || irq_short || irq_good;

    // Event word as stored, identification bits always present
    wire [15:0] evt_word = next_event | {10'h000, `RFF_EVT_ID};

    // Read data stands for one cycle only, zero otherwise
    always @(posedge clk_sys) begin
        if (rst) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            reg_rdata <= next_rdata;
        end else begin
            reg_rdata <= 16'h0000;
        end
    end

    // Host-written registers
    always @(posedge clk_sys) begin
        if (rst) begin
            receive_filter_control <= `RFF_CTL_RESET;
            receive_configuration  <= `RFF_CFG_RESET;
            station_addr           <= 48'h0;
            dma_only_receive       <= 1'b0;
        end else begin
            if (ctl_wr) begin
                receive_filter_control <= reg_wdata;
            end
            // Output follows the written bit at once, not a cycle late
            if (cfg_wr) begin
                receive_configuration <= reg_wdata;
                dma_only_receive      <= reg_wdata[`RFF_C_DMA];
            end
            if (addr01_wr) begin
                station_addr[15:0] <= reg_wdata;
            end
            if (addr23_wr) begin
                station_addr[31:16] <= reg_wdata;
            end
            if (addr45_wr) begin
                station_addr[47:32] <= reg_wdata;
            end
        end
    end

    // Byte counting, destination capture and store path
    always @(posedge clk_sys) begin
        if (rst) begin
            dest_addr   <= 48'h0;
            byte_cnt    <= {LEN_W{1'b0}};
            frame_len   <= {LEN_W{1'b0}};
            in_frame    <= 1'b0;
            store_valid <= 1'b0;
            store_byte  <= 8'h00;
        end else begin
            store_valid <= 1'b0;
            if (rx_start) begin
                in_frame  <= 1'b1;
                byte_cnt  <= {LEN_W{1'b0}};
                frame_len <= {LEN_W{1'b0}};
            end else begin
                if (in_frame && rx_byte_valid) begin
                    // Count saturates one past the limit to flag oversize
                    if (byte_cnt <= `RFF_MAX_LEN) begin
                        byte_cnt <= byte_cnt + 1'b1;
                    end
                    if (byte_cnt < `RFF_DEST_BYTES) begin
                        dest_addr <= {dest_addr[39:0], rx_byte};
                    end
                    if (byte_cnt < `RFF_MAX_LEN) begin
                        store_valid <= 1'b1;
                        store_byte  <= rx_byte;
                    end
                end
                if (in_frame) begin
                    frame_len <= byte_cnt;
                end else if (decide) begin
                    frame_len <= {LEN_W{1'b0}};
                end
                if (frame_done) begin
                    in_frame <= 1'b0;
                end
            end
        end
    end

    // Flags update on the cycle after end, from the frozen length;
    // a decision in the same cycle as an event read wins over the clear
    always @(posedge clk_sys) begin
        if (rst) begin
            receive_frame_event <= {10'h000, `RFF_EVT_ID};
            receive_status_copy <= {10'h000, `RFF_EVT_ID};
            length_copy         <= 16'h0000;
            frame_commit        <= 1'b0;
            frame_discard       <= 1'b0;
            irq                 <= 1'b0;
        end else begin
            frame_commit  <= 1'b0;
            frame_discard <= 1'b0;
            if (decide) begin
                frame_commit        <= next_keep;
                frame_discard       <= !next_keep;
                receive_frame_event <= evt_word;
                receive_status_copy <= evt_word;
                if (is_good) begin
                    length_copy <= {{(16-LEN_W){1'b0}}, frame_len};
                end
                irq <= irq_any;
            end else if (evt_rd) begin
                // Status copy is left alone on purpose
                receive_frame_event <= {10'h000, `RFF_EVT_ID};
                irq                 <= 1'b0;
            end
        end
    end
endmodule // rff_filter
`default_nettype wire

/* File: test/rff_checker.sv */
// Purpose: port assertions for the receive filter and event block
// Assumes: one clock domain, synchronous active-high reset
// Notes:   bound to rff_filter from tb_top
`timescale 1ns/10ps
`default_nettype none
`include "rff_defs.vh"
module rff_checker (
    // Clock, reset and register port
    input wire                   clk_sys, rst, reg_wr, reg_rd,
    input wire [`RFF_ADDR_W-1:0] reg_addr,
    input wire [15:0]            reg_wdata, reg_rdata,
    // Medium side
    input wire                   rx_start, rx_byte_valid, rx_end,
    input wire                   rx_fcs_ok, rx_hash_hit,
    input wire [7:0]             rx_byte,
    input wire [2:0]             rx_extra_bits,
    input wire [5:0]             rx_hash_index,
    // Store side
    input wire                   store_valid, frame_commit, frame_discard,
    input wire                   dma_only_receive, irq,
    input wire [7:0]             store_byte
);
    wire ev_rd = reg_rd && reg_addr == `RFF_OFS_EVENT;
    wire dec   = frame_commit | frame_discard;
    wire cfg9  = reg_wdata[9];
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    AST_CTL_ID: assert property (
        reg_rd && reg_addr == `RFF_OFS_CTL |=> reg_rdata[5:0] == `RFF_CTL_ID)
        else $error("control id bits wrong");
    AST_EVT_ID: assert property (ev_rd |=> reg_rdata[5:0] == `RFF_EVT_ID)
        else $error("event id bits wrong");
    AST_EVT_CLR: assert property (
        ev_rd ##1 (ev_rd && !dec) |=> reg_rdata == 16'h0004)
        else $error("event flags survived a read");
    AST_IRQ_CLR: assert property (ev_rd ##1 !dec |-> !irq)
        else $error("irq not cleared by event read");
    AST_IRQ_SRC: assert property ($rose(irq) |-> dec)
        else $error("irq rose without a frame decision");
    AST_ONE_DEC: assert property (!(frame_commit && frame_discard))
        else $error("commit and discard together");
    AST_DEC_TIME: assert property (dec |-> $past(rx_end, 2))
        else $error("decision not two cycles after frame end");
    AST_STORE: assert property (
        store_valid |-> $past(rx_byte_valid) && store_byte == $past(rx_byte))
        else $error("stored byte not the received one");
    AST_DMA: assert property (
        reg_wr && reg_addr == `RFF_OFS_CFG |=> dma_only_receive == $past(cfg9))
        else $error("dma-only output does not follow config");
endmodule // rff_checker
`default_nettype wire

/* File: test/rff_medium.sv */
// Purpose: medium-side model delivering received frames
// Assumes: frame qualifiers held from frame end to the decision cycle
// Notes:   qualifiers are inverted afterwards so stale values are caught
`timescale 1ns/10ps
`default_nettype none
module rff_medium (
    input  wire        clk_sys,
    output logic       rx_start, rx_byte_valid, rx_end, rx_fcs_ok, rx_hash_hit,
    output logic [7:0] rx_byte,
    output logic [2:0] rx_extra_bits,
    output logic [5:0] rx_hash_index
);
    initial {rx_start, rx_byte_valid, rx_end, rx_fcs_ok, rx_hash_hit,
             rx_byte, rx_extra_bits, rx_hash_index} = 0;
    task send(input [47:0] d, input [10:0] n, input ok, input [2:0] xb,
              input hh, input [5:0] hx);
        integer i;
        logic [47:0] sh;
        sh = d;
        @(posedge clk_sys) rx_start <= 1;
        for (i = 0; i < n; i++) begin
            @(posedge clk_sys) rx_start <= 0;
            rx_byte_valid <= 1;
            rx_byte <= i < 6 ? sh[47:40] : i[7:0] ^ 8'h5a;
            sh = sh << 8;
        end
        @(posedge clk_sys) rx_byte_valid <= 0;
        rx_byte <= ~rx_byte;
        rx_end <= 1;
        {rx_fcs_ok, rx_extra_bits, rx_hash_hit, rx_hash_index} <= {ok, xb, hh, hx};
        @(posedge clk_sys) rx_end <= 0;
        @(posedge clk_sys) {rx_fcs_ok, rx_extra_bits, rx_hash_hit, rx_hash_index}
            <= ~{ok, xb, hh, hx};
    endtask
endmodule // rff_medium
`default_nettype wire

/* File: test/tb_top.sv */
// Purpose: self-checking bench for the receive filter and event block
// Assumes: station address words are written low word of the value first
// Notes:   frame lengths sweep the 8, 64 and 1518 boundaries
`timescale 1ns/10ps
`default_nettype none
`include "rff_defs.vh"
module tb_top;
    logic clk_sys = 0, rst = 1, reg_wr = 0, reg_rd = 0;
    logic [`RFF_ADDR_W-1:0] reg_addr = 0;
    logic [15:0] reg_wdata = 0, v, ctl, cfg, e, mk;
    logic [5:0] hx;
    logic [47:0] d, sta = 48'h02a1b2c3d4e5, ones = '1;
    logic [10:0] n, lens [0:7] = '{5, 8, 63, 64, 200, 1518, 1519, 1525};
    logic ok, hh, a;
    logic [2:0] xb;
    wire [15:0] reg_rdata;
    wire rx_start, rx_byte_valid, rx_end, rx_fcs_ok, rx_hash_hit, irq;
    wire store_valid, frame_commit, frame_discard, dma_only_receive;
    wire [7:0] rx_byte, store_byte;
    wire [2:0] rx_extra_bits;
    wire [5:0] rx_hash_index;
    integer err_count = 0, n_compared = 0, seed = 32'hcbe4dfcf, i, n_c, n_d, n_st;
    always #50 clk_sys = ~clk_sys;
    rff_filter dut (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .rx_start(rx_start), .rx_byte_valid(rx_byte_valid),
        .rx_byte(rx_byte), .rx_end(rx_end), .rx_fcs_ok(rx_fcs_ok),
        .rx_extra_bits(rx_extra_bits), .rx_hash_hit(rx_hash_hit),
        .rx_hash_index(rx_hash_index), .store_valid(store_valid),
        .store_byte(store_byte), .frame_commit(frame_commit),
        .frame_discard(frame_discard), .dma_only_receive(dma_only_receive), .irq(irq));
    rff_medium med (.clk_sys(clk_sys), .rx_start(rx_start), .rx_byte_valid(rx_byte_valid),
        .rx_end(rx_end), .rx_fcs_ok(rx_fcs_ok), .rx_hash_hit(rx_hash_hit),
        .rx_byte(rx_byte), .rx_extra_bits(rx_extra_bits), .rx_hash_index(rx_hash_index));
    always @(posedge clk_sys)
        if (rx_start) {n_c, n_d, n_st} <= 0;
        else begin
            n_c <= n_c + frame_commit;
            n_d <= n_d + frame_discard;
            n_st <= n_st + store_valid;
        end
    function logic acc(input [15:0] c);
        logic g, m;
        g = ok && n >= 64 && n <= 1518;
        m = c[7] | (c[10] && d == sta) | (c[11] && d == ones)
            | (c[9] && d[40] && d != ones && hh) | (c[6] && !d[40] && hh);
        acc = m && n >= 8 && (!g || c[8]) && (ok || c[12])
            && (n >= 64 || c[13]) && (n <= 1518 || c[14]);
    endfunction
    function logic [15:0] exp_ev(input [15:0] c);
        logic g;
        g = ok && n >= 64 && n <= 1518;
        exp_ev = {1'b0, n > 1518, n < 64, !ok, d == ones && g && c[11],
                  2'b0, g, xb != 0, 7'b0};
    endfunction
    task chk(input string what, input [15:0] seen, input [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task wr(input [`RFF_ADDR_W-1:0] ad, input [15:0] wd);
        @(posedge clk_sys) {reg_wr, reg_addr, reg_wdata} <= {1'b1, ad, wd};
        @(posedge clk_sys) reg_wr <= 0;
    endtask
    task rd(input [`RFF_ADDR_W-1:0] ad, output [15:0] rv);
        @(posedge clk_sys) {reg_rd, reg_addr} <= {1'b1, ad};
        @(posedge clk_sys) reg_rd <= 0;
        #1 rv = reg_rdata;
    endtask
    task close_out;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        repeat (90000) @(posedge clk_sys);
        err_count++;
        close_out;
    end
    initial begin
        repeat (4) @(posedge clk_sys);
        rst <= 0;
        rd(`RFF_OFS_CTL, v); chk("ctl reset", v, `RFF_CTL_RESET);
        rd(`RFF_OFS_EVENT, v); chk("event reset", v, 16'h0004);
        rd(10'h3ff, v); chk("unmapped", v, 0);
        wr(`RFF_OFS_CTL, 16'hffc0); rd(`RFF_OFS_CTL, v);
        chk("ctl id", v & `RFF_ID_MASK, `RFF_CTL_ID);
        wr(`RFF_OFS_CFG, 16'h0200); wr(`RFF_OFS_CFG, 0);
        wr(`RFF_OFS_ADDR01, sta[15:0]);
        wr(`RFF_OFS_ADDR23, sta[31:16]);
        wr(`RFF_OFS_ADDR45, sta[47:32]);
        for (i = 0; i < 32; i++) begin
            ctl = i < 8 ? 16'h7f80 : $random(seed) & 16'h7fc0;
            cfg = $random(seed) & 16'h7100;
            n = lens[i % 8];
            d = {$random(seed), $random(seed)};
            case ($random(seed) & 3)
                0: d = sta;
                1: d = ones;
                2: d[40] = 1;
                default: d[40] = 0;
            endcase
            {ok, hh, xb} = $random(seed);
            hx = $random(seed);
            if (i % 4 == 1) cfg = (~ctl & 16'h7000) | 16'h0100;
            wr(`RFF_OFS_CTL, ctl); wr(`RFF_OFS_CFG, cfg);
            med.send(d, n, ok, xb, hh, hx);
            repeat (2) @(posedge clk_sys);
            #1 a = acc(ctl);
            e = exp_ev(ctl);
            chk("commit", n_c, a);
            chk("discard", n_d, !a);
            if (a) chk("stores", n_st, n > 1518 ? 1518 : n);
            if (n >= 8) chk("irq", irq, |(e & cfg));
            mk = 16'h7980;
            if (e[8] && hh && d != ones) begin
                mk = 16'hfd80;
                e[15:10] = hx;
            end
            rd(`RFF_OFS_EVENT, v);
            if (n >= 8) chk("event", v & mk, e);
            chk("irq clear", irq, 0);
            rd(`RFF_OFS_STATUS, v);
            if (n >= 8) chk("status", v & mk, e);
            if (n >= 8 && e[8]) begin
                rd(`RFF_OFS_LEN, v); chk("length", v, n);
            end
        end
        @(posedge clk_sys) {reg_rd, reg_addr} <= {1'b1, `RFF_OFS_EVENT};
        @(posedge clk_sys);
        @(posedge clk_sys) reg_rd <= 0;
        #1 chk("second read", reg_rdata, 16'h0004);
        close_out;
    end
endmodule // tb_top
bind rff_filter rff_checker chk_i (.clk_sys(clk_sys), .rst(rst), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .rx_start(rx_start), .rx_byte_valid(rx_byte_valid),
    .rx_end(rx_end), .rx_fcs_ok(rx_fcs_ok), .rx_hash_hit(rx_hash_hit),
    .rx_byte(rx_byte), .rx_extra_bits(rx_extra_bits), .rx_hash_index(rx_hash_index),
    .store_valid(store_valid), .frame_commit(frame_commit), .irq(irq),
    .frame_discard(frame_discard), .dma_only_receive(dma_only_receive),
    .store_byte(store_byte));
`default_nettype wire
